// file: src/bds_defs.svh
// constants for the driver status low-byte block
`ifndef BDS_DEFS_SVH
`define BDS_DEFS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define BDS_ADDR_W 7
`define BDS_DATA_W 16
`define BDS_OFS_DRIVER_STATUS_TWO 7'h02

// ----------------------------------------
// driver_status_two field positions
// ----------------------------------------
`define BDS_BIT_LS2_SINK 7
`define BDS_BIT_RES6 6
`define BDS_BIT_RES5 5
`define BDS_BIT_RES4 4
`define BDS_BIT_OUT_ONE 3
`define BDS_BIT_RES2 2
`define BDS_BIT_OUT_TWO 1
`define BDS_BIT_PARITY 0
`define BDS_HI_MSB 15
`define BDS_HI_LSB 8

// ----------------------------------------
// reset values
// ----------------------------------------
`define BDS_RST_WORD 16'h0000
`define BDS_RST_BYTE 8'h00
`define BDS_RST_BIT 1'b0
`define BDS_RES_VALUE 1'b0
`define BDS_PARITY_ODD 1'b1

`endif

// file: src/bds_pkg.sv
// types for the driver status low-byte block
package bds_pkg;

	// register port answer sequencer
	typedef enum logic [0:0] {
		BDS_IDLE,
		BDS_ANSWER
	} bds_port_state_type;

endpackage : bds_pkg

// file: src/bds_outctl.sv
// outputs-on control bit with fail-safe override
`timescale 1ns/100ps
`include "bds_defs.svh"

module bds_outctl (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// control
	input wire logic active_mode,
	input wire logic failsafe_pin_n,
	input wire logic outputs_on_wr,
	input wire logic outputs_on_wdata,
	// status
	output logic outputs_on_control,
	output logic failsafe_force
);

	// ----------------------------------------
	// control bit
	// ----------------------------------------
	logic outputs_on_r;
	logic outputs_on_nxt;
	logic force_r;
	logic force_nxt;

	always_comb begin
		outputs_on_nxt = outputs_on_r;
		force_nxt = force_r;
		if (!failsafe_pin_n) begin
			// pin low: cleared in active mode, frozen outside active mode
			if (active_mode) begin
				outputs_on_nxt = `BDS_RST_BIT;
				force_nxt = 1'b1;
			end
		end else begin
			force_nxt = `BDS_RST_BIT;
			if (outputs_on_wr) begin
				outputs_on_nxt = outputs_on_wdata;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			outputs_on_r <= `BDS_RST_BIT;
			force_r <= `BDS_RST_BIT;
		end else if (clk_en) begin
			outputs_on_r <= outputs_on_nxt;
			force_r <= force_nxt;
		end
	end

	assign outputs_on_control = outputs_on_r;
	assign failsafe_force = force_r;

endmodule : bds_outctl

// file: src/bds_status.sv
// driver_status_two low byte: fail-safe sink flag and output states
`timescale 1ns/100ps
`include "bds_defs.svh"

module bds_status (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// register port, already decoded from the serial frame
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [`BDS_ADDR_W-1:0] reg_addr,
	input wire logic [`BDS_DATA_W-1:0] reg_wdata,
	output logic reg_ack,
	output logic [`BDS_DATA_W-1:0] reg_rdata,
	// upper byte of the status word, kept outside
	input wire logic [7:0] status_hi,
	// fail-safe
	input wire logic active_mode,
	input wire logic failsafe_pin_n,
	input wire logic failsafe_latch_clr,
	input wire logic sink_fault,
	// outputs-on control write from the control register
	input wire logic outputs_on_wr,
	input wire logic outputs_on_wdata,
	// digital comparator results
	input wire logic low_side_one_open_load_cmp,
	input wire logic low_side_two_open_load_cmp,
	input wire logic low_side_one_drain_source_watch,
	input wire logic low_side_two_drain_source_watch,
	// state toward the gate drivers
	output logic outputs_on_control,
	output logic gate_sink_force,
	output logic failsafe_input_latch,
	output logic ls_two_failsafe_sink_flag,
	output logic out_one_digital_state,
	output logic out_two_digital_state
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------

	// odd parity: bit 0 makes the whole word odd
	function automatic logic bds_parity(
		input logic [`BDS_DATA_W-1:0] word
	);
		logic [`BDS_DATA_W-1:0] w;
		w = word;
		w[`BDS_BIT_PARITY] = `BDS_RST_BIT;
		return ^w ^ `BDS_PARITY_ODD;
	endfunction : bds_parity

	function automatic logic bds_hit(
		input logic [`BDS_ADDR_W-1:0] addr
	);
		return addr == `BDS_OFS_DRIVER_STATUS_TWO;
	endfunction : bds_hit

	// ----------------------------------------
	// outputs-on control
	// ----------------------------------------
	logic force_from_pin;

	bds_outctl u_outctl (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.active_mode(active_mode),
		.failsafe_pin_n(failsafe_pin_n),
		.outputs_on_wr(outputs_on_wr),
		.outputs_on_wdata(outputs_on_wdata),
		.outputs_on_control(outputs_on_control),
		.failsafe_force(force_from_pin)
	);

	// ----------------------------------------
	// fail-safe latch and sink flag
	// ----------------------------------------
	logic latch_r;
	logic latch_nxt;
	logic sink_flag_r;
	logic sink_flag_nxt;

	always_comb begin
		latch_nxt = latch_r;
		sink_flag_nxt = sink_flag_r;
		// set wins over clear; clear only once the pin is back high
		if (!failsafe_pin_n && active_mode) begin
			latch_nxt = 1'b1;
		end else if (failsafe_latch_clr && failsafe_pin_n) begin
			latch_nxt = `BDS_RST_BIT;
		end
		// under a driver fault the flag keeps its last value
		if (!sink_fault) begin
			sink_flag_nxt = latch_r;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_r <= `BDS_RST_BIT;
			sink_flag_r <= `BDS_RST_BIT;
		end else if (clk_en) begin
			latch_r <= latch_nxt;
			sink_flag_r <= sink_flag_nxt;
		end
	end

	assign failsafe_input_latch = latch_r;
	assign ls_two_failsafe_sink_flag = sink_flag_r;
	// sink forced from the pin edge on, held by the latch afterwards
	assign gate_sink_force = force_from_pin | latch_r;

	// ----------------------------------------
	// output digital states
	// ----------------------------------------
	logic out_one_r;
	logic out_one_nxt;
	logic out_two_r;
	logic out_two_nxt;

	// one flop of delay only; the comparators are not filtered here
	always_comb begin
		if (outputs_on_control) begin
			out_one_nxt = low_side_one_drain_source_watch;
			out_two_nxt = low_side_two_drain_source_watch;
		end else begin
			out_one_nxt = low_side_one_open_load_cmp;
			out_two_nxt = low_side_two_open_load_cmp;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_one_r <= `BDS_RST_BIT;
			out_two_r <= `BDS_RST_BIT;
		end else if (clk_en) begin
			out_one_r <= out_one_nxt;
			out_two_r <= out_two_nxt;
		end
	end

	assign out_one_digital_state = out_one_r;
	assign out_two_digital_state = out_two_r;

	// ----------------------------------------
	// status word assembly
	// ----------------------------------------
	logic [`BDS_DATA_W-1:0] status_word;

	always_comb begin
		status_word = `BDS_RST_WORD;
		status_word[`BDS_HI_MSB:`BDS_HI_LSB] = status_hi;
		status_word[`BDS_BIT_LS2_SINK] = sink_flag_r;
		status_word[`BDS_BIT_RES6] = `BDS_RES_VALUE;
		status_word[`BDS_BIT_RES5] = `BDS_RES_VALUE;
		status_word[`BDS_BIT_RES4] = `BDS_RES_VALUE;
		status_word[`BDS_BIT_OUT_ONE] = out_one_r;
		status_word[`BDS_BIT_RES2] = `BDS_RES_VALUE;
		status_word[`BDS_BIT_OUT_TWO] = out_two_r;
		status_word[`BDS_BIT_PARITY] = bds_parity(status_word);
	end

	// ----------------------------------------
	// register port
	// ----------------------------------------
	bds_pkg::bds_port_state_type port_r;
	bds_pkg::bds_port_state_type port_nxt;
	logic [`BDS_DATA_W-1:0] rdata_r;
	logic [`BDS_DATA_W-1:0] rdata_nxt;

	// writes are acknowledged but change nothing: the word is read-only
	always_comb begin
		port_nxt = port_r;
		rdata_nxt = rdata_r;
		case (port_r)
			bds_pkg::BDS_IDLE: begin
				if (reg_rd) begin
					port_nxt = bds_pkg::BDS_ANSWER;
					if (bds_hit(reg_addr)) begin
						rdata_nxt = status_word;
					end else begin
						rdata_nxt = `BDS_RST_WORD;
					end
				end else if (reg_wr) begin
					port_nxt = bds_pkg::BDS_ANSWER;
				end
			end
			bds_pkg::BDS_ANSWER: begin
				port_nxt = bds_pkg::BDS_IDLE;
			end
			default: begin
				port_nxt = bds_pkg::BDS_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_r <= bds_pkg::BDS_IDLE;
			rdata_r <= `BDS_RST_WORD;
		end else if (clk_en) begin
			port_r <= port_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_ack = port_r == bds_pkg::BDS_ANSWER;
	assign reg_rdata = rdata_r;

endmodule : bds_status

// file: bench/bds_status_checker.sv
// concurrent checks on the driver status low-byte ports
`timescale 1ns/100ps
`include "bds_defs.svh"
module bds_status_checker (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// register port
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [`BDS_ADDR_W-1:0] reg_addr,
	input wire logic reg_ack,
	input wire logic [`BDS_DATA_W-1:0] reg_rdata,
	// fail-safe and comparators
	input wire logic active_mode,
	input wire logic failsafe_pin_n,
	input wire logic sink_fault,
	input wire logic low_side_one_open_load_cmp,
	input wire logic low_side_two_open_load_cmp,
	input wire logic low_side_one_drain_source_watch,
	input wire logic low_side_two_drain_source_watch,
	// block state
	input wire logic outputs_on_control,
	input wire logic gate_sink_force,
	input wire logic failsafe_input_latch,
	input wire logic ls_two_failsafe_sink_flag,
	input wire logic out_one_digital_state,
	input wire logic out_two_digital_state
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic take, s1, s2;
	assign take = clk_en && !reg_ack;
	// reference mux follows the registered control bit, not the write
	assign s1 = outputs_on_control ? low_side_one_drain_source_watch
		: low_side_one_open_load_cmp;
	assign s2 = outputs_on_control ? low_side_two_drain_source_watch
		: low_side_two_open_load_cmp;
	a_ack_single_pulse:
	assert property (take && (reg_rd || reg_wr) |=> reg_ack ##1 !reg_ack)
		else $error("ack is not a single pulse");
	a_out_one_mux:
	assert property (clk_en && $past(rst_n)
		|=> out_one_digital_state == $past(s1))
		else $error("bit 3 source wrong");
	a_out_two_mux:
	assert property (clk_en && $past(rst_n)
		|=> out_two_digital_state == $past(s2))
		else $error("bit 1 source wrong");
	a_flag_follows_latch:
	assert property (clk_en && !sink_fault && $past(rst_n)
		|=> ls_two_failsafe_sink_flag == $past(failsafe_input_latch))
		else $error("sink flag does not follow latch");
	a_flag_fault_hold:
	assert property (clk_en && sink_fault
		|=> $stable(ls_two_failsafe_sink_flag))
		else $error("sink flag moved under fault");
	a_write_no_effect:
	assert property (take && reg_wr && !reg_rd |=> $stable(reg_rdata))
		else $error("write changed read data");
	a_failsafe_forces:
	assert property (clk_en && active_mode && !failsafe_pin_n
		|=> !outputs_on_control && gate_sink_force && failsafe_input_latch)
		else $error("fail-safe pin did not force sink");
	a_word_parity_res:
	assert property (take && reg_rd && reg_addr == `BDS_OFS_DRIVER_STATUS_TWO
		|=> (^reg_rdata) && reg_rdata[6:4] == 3'h0 && !reg_rdata[2])
		else $error("status word parity or reserved bits wrong");
endmodule : bds_status_checker
bind bds_status bds_status_checker chk_i (.*);

// file: bench/bds_host_model.sv
// host model issuing single reads and writes on the status port
`timescale 1ns/100ps
module bds_host_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// bench side
	input wire logic start,
	input wire logic wr_sel,
	input wire logic [6:0] addr_in,
	output logic [15:0] got,
	output logic done,
	// register port
	input wire logic reg_ack,
	input wire logic [15:0] reg_rdata,
	output logic reg_rd,
	output logic reg_wr,
	output logic [6:0] reg_addr
);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			{reg_rd, reg_wr, done, reg_addr, got} <= '0;
		end else begin
			done <= 1'b0;
			// request held until the ack edge, then dropped
			if ((reg_rd || reg_wr) && reg_ack) begin
				got <= reg_rdata;
				done <= 1'b1;
				{reg_rd, reg_wr} <= 2'h0;
			end else if (start && !reg_rd && !reg_wr) begin
				{reg_rd, reg_wr} <= {!wr_sel, wr_sel};
				reg_addr <= addr_in;
			end else if (!reg_rd && !reg_wr) begin
				// idle address wanders so stale values are never trusted
				reg_addr <= ~reg_addr;
			end
		end
	end
endmodule : bds_host_model

// file: bench/tb_top.sv
// self-checking bench for the driver status low-byte block
`timescale 1ns/100ps
`include "bds_defs.svh"
module tb_top;
	logic core_clk = 0, rst_n = 0, clk_en = 1, active_mode = 1;
	logic failsafe_pin_n = 1, failsafe_latch_clr = 0, sink_fault = 0;
	logic outputs_on_wr = 0, outputs_on_wdata = 0, start = 0, wr_sel = 0;
	logic [3:0] cmp = 4'h0;
	logic [7:0] status_hi = 8'h00;
	logic [6:0] addr_in = 7'h00, reg_addr;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, got;
	logic reg_rd, reg_wr, reg_ack, done, outputs_on_control, gate_sink_force;
	logic failsafe_input_latch, ls_two_failsafe_sink_flag, e1, e2;
	logic out_one_digital_state, out_two_digital_state;
	logic low_side_one_open_load_cmp, low_side_two_open_load_cmp;
	logic low_side_one_drain_source_watch, low_side_two_drain_source_watch;
	int err_total = 0, checks_done = 0, cyc = 0;
	assign {low_side_two_drain_source_watch, low_side_one_drain_source_watch,
		low_side_two_open_load_cmp, low_side_one_open_load_cmp} = cmp;
	bds_status uut (.*);
	bds_host_model host (.*);
	initial forever #12.5 core_clk = ~core_clk;
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
			err_total++;
		end
	endtask : chk
	task wrap_up;
		if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	// cycle ceiling well above the few hundred the run needs
	always @(posedge core_clk) if (++cyc == 5000) begin
		err_total++;
		wrap_up;
	end
	function logic [15:0] word(input logic [7:0] h, input logic f, a, b);
		logic [15:0] w;
		w = {h, f, 3'h0, a, 1'b0, b, 1'b0};
		w[0] = ~^w;
		return w;
	endfunction : word
	task xfer(input logic w, input logic [6:0] a);
		@(posedge core_clk) {start, wr_sel, addr_in} <= {1'b1, w, a};
		@(posedge core_clk) start <= 1'b0;
		for (int i = 0; i < 8 && done !== 1'b1; i++) @(posedge core_clk);
		chk("transfer done", {15'h0, done}, 16'h0001);
	endtask : xfer
	task pulse_on(input logic v);
		@(posedge core_clk) {outputs_on_wr, outputs_on_wdata} <= {1'b1, v};
		@(posedge core_clk) outputs_on_wr <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask : pulse_on
	task t_mux;
		for (int m = 0; m < 2; m++) begin
			pulse_on(m[0]);
			for (int i = 0; i < 16; i++) begin
				@(posedge core_clk)
					{cmp, status_hi} <= {i[3:0], i[3:0], ~i[3:0]};
				repeat (3) @(posedge core_clk);
				e1 = m[0] ? cmp[2] : cmp[0];
				e2 = m[0] ? cmp[3] : cmp[1];
				chk("out states", {out_one_digital_state, out_two_digital_state},
					{e1, e2});
				xfer(0, `BDS_OFS_DRIVER_STATUS_TWO);
				chk("status word", got, word(status_hi, 0, e1, e2));
			end
		end
	endtask : t_mux
	task t_failsafe;
		@(posedge core_clk) failsafe_pin_n <= 1'b0;
		pulse_on(1'b1);
		chk("forced", {outputs_on_control, gate_sink_force, failsafe_input_latch,
			ls_two_failsafe_sink_flag}, 16'h0007);
		xfer(1, `BDS_OFS_DRIVER_STATUS_TWO);
		xfer(0, `BDS_OFS_DRIVER_STATUS_TWO);
		chk("flag after write", got, word(status_hi, 1, 1, 1));
		@(posedge core_clk)
			{failsafe_pin_n, sink_fault, failsafe_latch_clr} <= 3'h7;
		@(posedge core_clk) failsafe_latch_clr <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("fault hold", {gate_sink_force, failsafe_input_latch,
			ls_two_failsafe_sink_flag}, 16'h0001);
		@(posedge core_clk) sink_fault <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("flag cleared", {15'h0, ls_two_failsafe_sink_flag}, 16'h0000);
	endtask : t_failsafe
	task t_unmapped;
		xfer(0, 7'h03);
		chk("next index", got, 16'h0000);
		xfer(0, 7'h7f);
		chk("top index", got, 16'h0000);
	endtask : t_unmapped
	// pin low outside active mode only freezes; then a clock-enable freeze
	task t_hold;
		pulse_on(1'b1);
		@(posedge core_clk) {active_mode, failsafe_pin_n} <= 2'h0;
		pulse_on(1'b0);
		chk("standby pin low", {outputs_on_control, gate_sink_force,
			failsafe_input_latch}, 16'h0004);
		@(posedge core_clk) {active_mode, failsafe_pin_n} <= 2'h3;
		@(posedge core_clk) {clk_en, cmp} <= {1'b0, 4'h0};
		repeat (3) @(posedge core_clk);
		chk("frozen states", {out_one_digital_state, out_two_digital_state},
			16'h0003);
		@(posedge core_clk) clk_en <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk("thawed states", {out_one_digital_state, out_two_digital_state},
			16'h0000);
	endtask : t_hold
	initial begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		t_mux;
		t_failsafe;
		t_unmapped;
		t_hold;
		wrap_up;
	end
endmodule : tb_top
